// ==== src/cegs_top.sv ====
// top of the exposure and gain control block
`timescale 1ns/100ps
// Summary of operation
// RULE_01 - manual exposure uses programmed duration exactly
// RULE_02 - one-shot exposure adjusts, then returns to off
// RULE_03 - continuous exposure recomputed every measured frame
// RULE_04 - auto exposure clamped to lower/upper limits
// RULE_05 - trigger enable drops continuous exposure to off
// RULE_06 - ultrashort or standard range, standard if absent
// RULE_07 - manual gain uses programmed value exactly
// RULE_08 - one-shot gain adjusts, then returns to off
// RULE_09 - continuous gain follows brightness every frame
// RULE_10 - auto gain clamped to lower/upper limits
// RULE_11 - digital shift after conversion, only when enabled
// RULE_12 - decimation drops columns and rows
// RULE_13 - sequencer and multi exposure mutually exclusive
// RULE_14 - eight stored sets, total count sets cycle
// RULE_15 - software stops sequencer, enters config before edits
// RULE_16 - load copies set to live, save stores
// RULE_17 - stored sets locked while sequencer runs
// RULE_18 - trigger width and range locked while running
// RULE_19 - restart makes next frame use first set
// RULE_20 - multi exposure cycles up to four groups
// RULE_21 - non-rolling shutter halves multi exposure rate
// RULE_22 - auto modes steer toward target brightness
// RULE_23 - one-shot ends within tolerance or at limit
module cegs_top #(
   parameter int  EW           = cegs_pkg::EXPO_W,
   parameter int  GW           = cegs_pkg::GAIN_W,
   parameter int  SW           = cegs_pkg::SHIFT_W,
   parameter int  NSETS        = cegs_pkg::SEQ_SETS,
   parameter int  NGRPS        = cegs_pkg::HDR_GRPS,
   parameter bit  ULTRA_OPTION = 1'b1
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   // live settings
   input  wire logic                       expo_wr,
   input  wire logic [EW-1:0]              expo_wdata,
   input  wire logic                       gain_wr,
   input  wire logic [GW-1:0]              gain_wdata,
   input  wire logic [SW-1:0]              dshift_in,
   input  wire logic                       dshift_en_in,
   input  wire logic                       expo_auto_wr,
   input  wire logic [1:0]                 expo_auto_wdata,
   input  wire logic                       gain_auto_wr,
   input  wire logic [1:0]                 gain_auto_wdata,
   input  wire logic [EW-1:0]              expo_lo,
   input  wire logic [EW-1:0]              expo_hi,
   input  wire logic [GW-1:0]              gain_lo,
   input  wire logic [GW-1:0]              gain_hi,
   input  wire logic [7:0]                 target_bright,
   input  wire logic                       range_wr,
   input  wire logic                       range_wdata,
   input  wire logic                       trig_width_wr,
   input  wire logic [15:0]                trig_width_wdata,
   input  wire logic                       trig_en,
   input  wire logic [1:0]                 shutter_mode,
   input  wire logic [cegs_pkg::DEC_W-1:0] decim_h,
   input  wire logic [cegs_pkg::DEC_W-1:0] decim_v,
   // sequencer control
   input  wire logic                       seq_mode,
   input  wire logic                       seq_cfg_mode,
   input  wire logic [3:0]                 seq_total,
   input  wire logic [2:0]                 seq_sel,
   input  wire logic                       seq_load,
   input  wire logic                       seq_save,
   input  wire logic                       seq_restart,
   // multi exposure control
   input  wire logic                       multi_expo_en,
   input  wire logic [1:0]                 multi_expo_index,
   input  wire logic [2:0]                 multi_expo_count,
   input  wire logic                       multi_expo_wr,
   input  wire logic [EW-1:0]              multi_expo_duration,
   input  wire logic [GW-1:0]              multi_expo_amp,
   // frame timing and measurement
   input  wire logic                       frame_start,
   input  wire logic                       meas_valid,
   input  wire logic [7:0]                 meas_bright,
   // pixels
   input  wire logic                       pix_valid,
   input  wire logic                       pix_sof,
   input  wire logic                       pix_sol,
   input  wire logic [cegs_pkg::PIX_W-1:0] pix_data,
   // outputs to sensor and host
   output logic                            frame_go,
   output logic [EW-1:0]                   frame_expo,
   output logic [GW-1:0]                   frame_gain,
   output logic [2:0]                      frame_set,
   output logic [1:0]                      expo_auto_mode,
   output logic [1:0]                      gain_auto_mode,
   output logic [EW-1:0]                   expo_live,
   output logic [GW-1:0]                   gain_live,
   output logic                            range_mode,
   output logic [15:0]                     trig_width,
   output logic                            seq_active,
   output logic                            multi_expo_active,
   output logic                            out_valid,
   output logic [cegs_pkg::PIX_W-1:0]      out_data
);
   cegs_pkg::cegs_run_t run, next_run;
   logic [EW-1:0] seq_expo [NSETS];
   logic [GW-1:0] seq_gain [NSETS];
   logic [SW-1:0] seq_shift [NSETS];
   logic [EW-1:0] next_seq_expo [NSETS];
   logic [GW-1:0] next_seq_gain [NSETS];
   logic [SW-1:0] next_seq_shift [NSETS];
   logic [EW-1:0] grp_dur [NGRPS];
   logic [GW-1:0] grp_amp [NGRPS];
   logic [EW-1:0] next_grp_dur [NGRPS];
   logic [GW-1:0] next_grp_amp [NGRPS];
   logic [SW-1:0] shift_live, next_shift_live, app_shift;
   logic          app_shift_en;
   logic [EW-1:0] next_expo_live, next_frame_expo;
   logic [GW-1:0] next_gain_live, next_frame_gain;
   logic [1:0]    next_expo_mode, next_gain_mode;
   logic          next_range, trig_q;
   logic [15:0]   next_twid;
   logic [2:0]    seq_idx, next_seq_idx, next_frame_set;
   logic [1:0]    grp_idx, next_grp_idx;
   logic          restart_pend, next_restart_pend;
   logic          half_skip, next_half_skip, next_frame_go;

   cegs_auto_if #(.W(EW)) ae_if ();
   cegs_auto_if #(.W(GW)) ag_if ();

   // auto units see live value, window and brightness
   assign ae_if.cur    = expo_live;
   assign ae_if.lo     = expo_lo;
   assign ae_if.hi     = expo_hi;
   assign ae_if.meas   = meas_bright;
   assign ae_if.target = target_bright;
   assign ag_if.cur    = gain_live;
   assign ag_if.lo     = gain_lo;
   assign ag_if.hi     = gain_hi;
   assign ag_if.meas   = meas_bright;
   assign ag_if.target = target_bright;

   cegs_auto_step #(.W(EW)) u_ae (.a(ae_if));
   cegs_auto_step #(.W(GW)) u_ag (.a(ag_if));

   // wrap an index at a programmed count, zero count behaves as one
   function automatic logic [2:0] wrap_inc(input logic [2:0] i, input logic [3:0] n);
      wrap_inc = ({1'b0, i} + 4'h1 >= n) ? 3'h0 : i + 3'h1;
   endfunction : wrap_inc

   // run state: whichever mode got in first keeps the other out
   always_comb begin
      next_run = run;
      case (run)
         cegs_pkg::RUN_IDLE: begin
            if (seq_mode) begin
               next_run = cegs_pkg::RUN_SEQ;   // [RULE_13]
            end else if (multi_expo_en) begin
               next_run = cegs_pkg::RUN_HDR;   // [RULE_13]
            end
         end
         cegs_pkg::RUN_SEQ: begin
            if (!seq_mode) begin
               next_run = cegs_pkg::RUN_IDLE;
            end
         end
         cegs_pkg::RUN_HDR: begin
            if (!multi_expo_en) begin
               next_run = cegs_pkg::RUN_IDLE;
            end
         end
         default: next_run = cegs_pkg::RUN_IDLE;
      endcase
   end

   // stored sets and groups; set saves only outside a running sequence, group writes at any time
   always_comb begin
      next_seq_expo  = seq_expo;
      next_seq_gain  = seq_gain;
      next_seq_shift = seq_shift;
      next_grp_dur   = grp_dur;
      next_grp_amp   = grp_amp;
      if (seq_save && seq_cfg_mode && run != cegs_pkg::RUN_SEQ) begin // [RULE_17] [RULE_15]
         next_seq_expo[seq_sel] = expo_live; // [RULE_16]
         next_seq_gain[seq_sel] = gain_live; // [RULE_16]
         next_seq_shift[seq_sel] = shift_live; // [RULE_16]
      end
      if (multi_expo_wr) begin
         next_grp_dur[multi_expo_index] = multi_expo_duration; // [RULE_20]
         next_grp_amp[multi_expo_index] = multi_expo_amp; // [RULE_20]
      end
   end

   // live settings and auto mode bookkeeping
   always_comb begin
      next_expo_live  = expo_live;
      next_gain_live  = gain_live;
      next_shift_live = dshift_in;
      next_expo_mode  = expo_auto_mode;
      next_gain_mode  = gain_auto_mode;
      next_range      = range_mode;
      next_twid       = trig_width;
      if (expo_wr) begin
         next_expo_live = expo_wdata; // [RULE_01]
      end
      if (gain_wr) begin
         next_gain_live = gain_wdata; // [RULE_07]
      end
      if (seq_load && run != cegs_pkg::RUN_SEQ) begin
         next_expo_live = seq_expo[seq_sel]; // [RULE_16]
         next_gain_live = seq_gain[seq_sel]; // [RULE_16]
         next_shift_live = seq_shift[seq_sel]; // [RULE_16]
      end
      // auto loops run once per measured frame outside stored modes
      if (meas_valid && run == cegs_pkg::RUN_IDLE) begin
         if (expo_auto_mode != cegs_pkg::AUTO_OFF) begin
            next_expo_live = ae_if.nxt; // [RULE_03] [RULE_02]
         end
         if (gain_auto_mode != cegs_pkg::AUTO_OFF) begin
            next_gain_live = ag_if.nxt; // [RULE_09] [RULE_08]
         end
         if (expo_auto_mode == cegs_pkg::AUTO_ONCE && ae_if.done) begin
            next_expo_mode = cegs_pkg::AUTO_OFF; // [RULE_02] [RULE_23]
         end
         if (gain_auto_mode == cegs_pkg::AUTO_ONCE && ag_if.done) begin
            next_gain_mode = cegs_pkg::AUTO_OFF; // [RULE_08] [RULE_23]
         end
      end
      if (trig_en && !trig_q && expo_auto_mode == cegs_pkg::AUTO_CONT) begin
         next_expo_mode = cegs_pkg::AUTO_OFF; // [RULE_05]
      end
      // host writes win over the self-clear in the same cycle
      if (expo_auto_wr) begin
         next_expo_mode = expo_auto_wdata;
      end
      if (gain_auto_wr) begin
         next_gain_mode = gain_auto_wdata;
      end
      if (run != cegs_pkg::RUN_SEQ) begin
         if (range_wr) begin
            next_range = ULTRA_OPTION ? range_wdata : cegs_pkg::RANGE_STD; // [RULE_06] [RULE_18]
         end
         if (trig_width_wr) begin
            next_twid = trig_width_wdata; // [RULE_18]
         end
      end
   end

   // per frame choice of parameters
   always_comb begin
      next_frame_go     = 1'b0;
      next_frame_expo   = frame_expo;
      next_frame_gain   = frame_gain;
      next_frame_set    = frame_set;
      next_seq_idx      = seq_idx;
      next_grp_idx      = grp_idx;
      next_half_skip    = half_skip;
      next_restart_pend = restart_pend | seq_restart;
      if (run != cegs_pkg::RUN_HDR) begin
         next_half_skip = 1'b0;
         next_grp_idx   = 2'h0;
      end
      if (run != cegs_pkg::RUN_SEQ && !seq_restart) begin
         next_seq_idx = 3'h0;
      end
      if (frame_start) begin
         case (run)
            cegs_pkg::RUN_SEQ: begin
               next_frame_go = 1'b1;
               next_frame_set = (restart_pend | seq_restart) ? 3'h0 : seq_idx; // [RULE_19]
               next_frame_expo = seq_expo[next_frame_set];
               next_frame_gain = seq_gain[next_frame_set];
               next_seq_idx = wrap_inc(next_frame_set, seq_total); // [RULE_14]
               next_restart_pend = 1'b0;
            end
            cegs_pkg::RUN_HDR: begin
               // only rolling shutter runs every frame
               if (half_skip && shutter_mode != cegs_pkg::SHUT_ROLL) begin
                  next_half_skip = 1'b0; // [RULE_21]
               end else begin
                  next_frame_go = 1'b1;
                  next_frame_set = {1'b0, grp_idx};
                  next_frame_expo = grp_dur[grp_idx]; // [RULE_20]
                  next_frame_gain = grp_amp[grp_idx]; // [RULE_20]
                  next_grp_idx = 2'(wrap_inc({1'b0, grp_idx}, {1'b0, multi_expo_count}));
                  next_half_skip = (shutter_mode != cegs_pkg::SHUT_ROLL); // [RULE_21]
               end
            end
            default: begin
               next_frame_go = 1'b1;
               next_frame_set = 3'h0;
               next_frame_expo = expo_live; // [RULE_01]
               next_frame_gain = gain_live; // [RULE_07]
            end
         endcase
      end
   end

   // digital shift follows the active set while sequencing
   always_comb begin
      app_shift    = (run == cegs_pkg::RUN_SEQ) ? seq_shift[frame_set] : shift_live;
      app_shift_en = dshift_en_in;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         run <= cegs_pkg::RUN_IDLE;
         seq_expo <= '{default: cegs_pkg::EXPO_RST};
         seq_gain <= '{default: cegs_pkg::GAIN_RST};
         seq_shift <= '{default: '0};
         grp_dur <= '{default: cegs_pkg::EXPO_RST};
         grp_amp <= '{default: cegs_pkg::GAIN_RST};
         expo_live <= cegs_pkg::EXPO_RST;
         gain_live <= cegs_pkg::GAIN_RST;
         shift_live <= '0;
         expo_auto_mode <= cegs_pkg::AUTO_OFF;
         gain_auto_mode <= cegs_pkg::AUTO_OFF;
         range_mode <= cegs_pkg::RANGE_STD;
         trig_width <= cegs_pkg::TWID_RST;
         trig_q <= 1'b0;
         frame_go <= 1'b0;
         frame_expo <= cegs_pkg::EXPO_RST;
         frame_gain <= cegs_pkg::GAIN_RST;
         frame_set <= 3'h0;
         seq_idx <= 3'h0;
         grp_idx <= 2'h0;
         restart_pend <= 1'b0;
         half_skip <= 1'b0;
         seq_active <= 1'b0;
         multi_expo_active <= 1'b0;
      end else begin
         run <= next_run;
         seq_expo <= next_seq_expo;
         seq_gain <= next_seq_gain;
         seq_shift <= next_seq_shift;
         grp_dur <= next_grp_dur;
         grp_amp <= next_grp_amp;
         expo_live <= next_expo_live;
         gain_live <= next_gain_live;
         shift_live <= next_shift_live;
         expo_auto_mode <= next_expo_mode;
         gain_auto_mode <= next_gain_mode;
         range_mode <= next_range;
         trig_width <= next_twid;
         trig_q <= trig_en;
         frame_go <= next_frame_go;
         frame_expo <= next_frame_expo;
         frame_gain <= next_frame_gain;
         frame_set <= next_frame_set;
         seq_idx <= next_seq_idx;
         grp_idx <= next_grp_idx;
         restart_pend <= next_restart_pend;
         half_skip <= next_half_skip;
         seq_active <= (next_run == cegs_pkg::RUN_SEQ);
         multi_expo_active <= (next_run == cegs_pkg::RUN_HDR);
      end
   end

   // gain after conversion and decimation on the pixel stream
   cegs_pix_path #(
      .PW (cegs_pkg::PIX_W),
      .DW (cegs_pkg::DEC_W),
      .SW (SW)
   ) u_pix (
      .core_clk  (core_clk),
      .rst       (rst),
      .pix_valid (pix_valid),
      .pix_sof   (pix_sof),
      .pix_sol   (pix_sol),
      .pix_data  (pix_data),
      .decim_h   (decim_h),
      .decim_v   (decim_v),
      .dshift    (app_shift),
      .dshift_en (app_shift_en),
      .out_valid (out_valid),
      .out_data  (out_data)
   );
endmodule : cegs_top

// ==== src/cegs_pkg.sv ====
// shared constants
package cegs_pkg;
   localparam int EXPO_W    = 24;
   localparam int GAIN_W    = 10;
   localparam int BRI_W     = 8;
   localparam int SHIFT_W   = 3;
   localparam int PIX_W     = 12;
   localparam int DEC_W     = 4;
   localparam int SEQ_SETS  = 8;
   localparam int HDR_GRPS  = 4;
   localparam logic [BRI_W-1:0]  AUTO_TOL  = 8'h08;
   localparam logic [EXPO_W-1:0] EXPO_RST  = 24'h002710;
   localparam logic [GAIN_W-1:0] GAIN_RST  = 10'h000;
   localparam logic [DEC_W-1:0]  DEC_RST   = 4'h1;
   localparam logic [15:0]       TWID_RST  = 16'h0000;
   // auto mode codes as seen on the mode ports
   localparam logic [1:0] AUTO_OFF  = 2'h0;
   localparam logic [1:0] AUTO_ONCE = 2'h1;
   localparam logic [1:0] AUTO_CONT = 2'h2;
   // exposure range mode codes
   localparam logic RANGE_STD   = 1'b0;
   localparam logic RANGE_ULTRA = 1'b1;
   // sensor shutter mode codes
   localparam logic [1:0] SHUT_ROLL  = 2'h0;
   localparam logic [1:0] SHUT_GRST  = 2'h1;
   localparam logic [1:0] SHUT_TROLL = 2'h2;
   typedef enum logic [1:0] {RUN_IDLE, RUN_SEQ, RUN_HDR} cegs_run_t;
endpackage : cegs_pkg

// ==== src/cegs_auto_if.sv ====
// top to auto unit carrier
`timescale 1ns/100ps
interface cegs_auto_if #(parameter int W = 8);
   logic [W-1:0] cur;
   logic [W-1:0] lo;
   logic [W-1:0] hi;
   logic [7:0]   meas;
   logic [7:0]   target;
   logic [W-1:0] nxt;
   logic         done;
   modport ctl  (output cur, lo, hi, meas, target, input nxt, done);
   modport unit (input cur, lo, hi, meas, target, output nxt, done);
endinterface : cegs_auto_if

// ==== src/cegs_auto_step.sv ====
// one brightness driven adjust step with limit clamp
`timescale 1ns/100ps
module cegs_auto_step #(
   parameter int W = 8
) (
   cegs_auto_if.unit a
);
   // keep the value inside the programmed auto window
   function automatic logic [W-1:0] clamp(input logic [W-1:0] v, input logic [W-1:0] l,
                                          input logic [W-1:0] h);
      clamp = (v < l) ? l : ((v > h) ? h : v);
   endfunction : clamp

   logic [W-1:0] delta;
   logic [W:0]   up_sum;
   logic [8:0]   meas_hi;
   logic [8:0]   tgt_hi;

   // proportional step of one eighth keeps the loop from ringing
   always_comb begin
      delta   = (a.cur >> 3) + {{(W-1){1'b0}}, 1'b1};
      up_sum  = {1'b0, a.cur} + {1'b0, delta};
      meas_hi = {1'b0, a.meas} + {1'b0, cegs_pkg::AUTO_TOL};
      tgt_hi  = {1'b0, a.target} + {1'b0, cegs_pkg::AUTO_TOL};
      if (meas_hi < {1'b0, a.target}) begin
         // too dark: raise toward target [RULE_22]
         a.nxt  = up_sum[W] ? a.hi : clamp(up_sum[W-1:0], a.lo, a.hi); // [RULE_04] [RULE_10]
         a.done = (a.cur >= a.hi); // [RULE_23]
      end else if ({1'b0, a.meas} > tgt_hi) begin
         // too bright: lower toward target [RULE_22]
         a.nxt  = (a.cur < delta) ? a.lo : clamp(a.cur - delta, a.lo, a.hi); // [RULE_04] [RULE_10]
         a.done = (a.cur <= a.lo); // [RULE_23]
      end else begin
         a.nxt  = clamp(a.cur, a.lo, a.hi);
         a.done = 1'b1; // [RULE_23]
      end
   end
endmodule : cegs_auto_step

// ==== src/cegs_pix_path.sv ====
// pixel path: decimation and digital shift after conversion
`timescale 1ns/100ps
module cegs_pix_path #(
   parameter int PW = cegs_pkg::PIX_W,
   parameter int DW = cegs_pkg::DEC_W,
   parameter int SW = cegs_pkg::SHIFT_W
) (
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire logic          pix_valid,
   input  wire logic          pix_sof,
   input  wire logic          pix_sol,
   input  wire logic [PW-1:0] pix_data,
   input  wire logic [DW-1:0] decim_h,
   input  wire logic [DW-1:0] decim_v,
   input  wire logic [SW-1:0] dshift,
   input  wire logic          dshift_en,
   output logic               out_valid,
   output logic [PW-1:0]      out_data
);
   logic [DW-1:0] col, next_col, row, next_row;
   logic          next_valid;
   logic [PW-1:0] next_data;
   logic [DW-1:0] col_c, row_c;
   logic [PW+7:0] shifted;

   // phase counters; a factor of 0 is treated as 1
   always_comb begin
      // a line start steps the row phase before its pixel is judged
      col_c = pix_sol ? '0 : col;
      row_c = pix_sof ? '0 : (!pix_sol ? row : ((row + 1'b1 >= decim_v) ? '0 : row + 1'b1));
      next_col = col;
      next_row = row_c;
      if (pix_valid) begin
         next_col = (col_c + 1'b1 >= decim_h) ? '0 : col_c + 1'b1;
      end
      // keep only first column and row of each group [RULE_12]
      next_valid = pix_valid && (col_c == '0) && (row_c == '0);
      // shift with saturation so bright pixels do not wrap [RULE_11]
      shifted   = {8'h00, pix_data} << dshift;
      next_data = pix_data;
      if (dshift_en) begin
         next_data = (|shifted[PW+7:PW]) ? {PW{1'b1}} : shifted[PW-1:0]; // [RULE_11]
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         col       <= '0;
         row       <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         col       <= next_col;
         row       <= next_row;
         out_valid <= next_valid;
         out_data  <= next_data;
      end
   end
endmodule : cegs_pix_path

// ==== sim/cegs_sensor_model.sv ====
// 4 by 4 sensor frame per start pulse
`timescale 1ns/100ps
module cegs_sensor_model (
   input  wire logic   core_clk,
   input  wire logic   pix_start,
   output logic        pix_valid,
   output logic        pix_sof,
   output logic        pix_sol,
   output logic [11:0] pix_data
);
   logic [4:0] n = 5'h10;
   logic       t = 1'b0;
   // idle data toggles, never stale
   always @(posedge core_clk) begin
      t <= ~t;
      if (pix_start) n <= 5'h00;
      else if (n != 5'h10) n <= n + 5'h01;
   end
   assign pix_valid = (n != 5'h10);
   assign pix_sof   = (n == 5'h00);
   assign pix_sol   = pix_valid && (n[1:0] == 2'h0);
   assign pix_data  = pix_valid ? 12'h0a0 + {8'h00, n[3:0]} : {12{t}};
endmodule : cegs_sensor_model

// ==== sim/cegs_properties.sv ====
// port assertions
`timescale 1ns/100ps
module cegs_props (
   input wire logic        core_clk, rst, expo_wr, gain_wr, seq_load, meas_valid, trig_en, expo_auto_wr,
   input wire logic        range_wr, trig_width_wr, frame_start, seq_mode, multi_expo_en, pix_valid,
   input wire logic        dshift_en_in, frame_go, range_mode, seq_active, multi_expo_active, out_valid,
   input wire logic [23:0] expo_wdata, expo_lo, expo_hi, expo_live, frame_expo,
   input wire logic [9:0]  gain_wdata, gain_live,
   input wire logic [1:0]  expo_auto_mode,
   input wire logic [15:0] trig_width,
   input wire logic [3:0]  decim_h, decim_v,
   input wire logic [11:0] pix_data, out_data
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_expo_manual: assert property (expo_wr && !seq_load && !meas_valid |=> expo_live == $past(expo_wdata))
      else $error("expo lost");
   a_gain_manual: assert property (gain_wr && !seq_load && !meas_valid |=> gain_live == $past(gain_wdata))
      else $error("gain lost");
   a_expo_clamp: assert property (meas_valid && expo_auto_mode != 2'h0 && !seq_active && !multi_expo_active
      |=> expo_live >= $past(expo_lo) && expo_live <= $past(expo_hi)) else $error("expo off limits");
   a_trig_drop: assert property ($rose(trig_en) && expo_auto_mode == 2'h2 && !expo_auto_wr
      |=> ##[0:1] expo_auto_mode == 2'h0) else $error("auto kept");
   a_run_mutex: assert property (!(seq_active && multi_expo_active)) else $error("both modes");
   a_setting_lock: assert property (seq_active && (range_wr || trig_width_wr)
      |=> $stable(range_mode) && $stable(trig_width)) else $error("lock broken");
   a_idle_frame: assert property (frame_start && !seq_active && !multi_expo_active && !seq_mode && !multi_expo_en
      |=> frame_go && frame_expo == $past(expo_live)) else $error("idle frame");
   a_pix_plain: assert property (pix_valid && !dshift_en_in && decim_h <= 4'h1 && decim_v <= 4'h1
      |=> out_valid && out_data == $past(pix_data)) else $error("pixel altered");
endmodule : cegs_props
bind cegs_top cegs_props u_props (.*);

// ==== sim/test_cegs_top.sv ====
// bench for the control block
`timescale 1ns/100ps
module test_cegs_top;
   logic core_clk = '0, rst = '1, dshift_en_in = '0, trig_en = '0, seq_mode = '0, seq_cfg_mode = '0, multi_expo_en = '0;
   logic [11:0] s = '0;
   logic [23:0] d = '0, expo_lo = 24'h000010, expo_hi = 24'h000500;
   logic [9:0]  gain_lo = '0, gain_hi = 10'h0ff;
   logic [7:0]  target_bright = 8'h80;
   logic [3:0]  decim_h = 4'h1, decim_v = 4'h1, seq_total = 4'h2;
   logic [2:0]  dshift_in = '0, seq_sel = '0, multi_expo_count = 3'h2;
   logic [1:0]  shutter_mode = '0, multi_expo_index = '0;
   // strobes and data fan out from s and d
   wire logic expo_wr = s[0], gain_wr = s[1], expo_auto_wr = s[2], gain_auto_wr = s[3], meas_valid = s[4];
   wire logic frame_start = s[5], seq_save = s[6], seq_load = s[7], seq_restart = s[8], range_wr = s[9];
   wire logic multi_expo_wr = s[10], pix_start = s[11], range_wdata = d[0], trig_width_wr = s[9];
   wire logic [23:0] expo_wdata = d, multi_expo_duration = d;
   wire logic [9:0]  gain_wdata = d[9:0], multi_expo_amp = d[9:0];
   wire logic [7:0]  meas_bright = d[7:0];
   wire logic [1:0]  expo_auto_wdata = d[1:0], gain_auto_wdata = d[1:0];
   wire logic [15:0] trig_width_wdata = d[15:0], trig_width;
   wire logic pix_valid, pix_sof, pix_sol, frame_go, range_mode, seq_active, multi_expo_active, out_valid;
   wire logic [23:0] frame_expo, expo_live;
   wire logic [11:0] pix_data, out_data;
   wire logic [9:0]  frame_gain, gain_live;
   wire logic [2:0]  frame_set;
   wire logic [1:0]  expo_auto_mode, gain_auto_mode;
   int n_fail = 0, total_checks = 0, cyc = 0, gos;
   logic [11:0] got[$];
   cegs_top uut (.*);
   cegs_sensor_model sensor (.*);
   // clock, ceiling, kept pixels
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         give_verdict();
      end
      if (out_valid === 1'b1) got.push_back(out_data);
   end
   task chk(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // strobe k with data v
   task pulse(input int k, input logic [23:0] v);
      @(posedge core_clk);
      s <= 12'h001 << k;
      d <= v;
      @(posedge core_clk);
      s <= '0;
      #1;
   endtask : pulse
   task frm(input logic [23:0] e);
      pulse(5, 24'h0);
      chk(frame_go, 1'b1);
      chk(frame_expo, e);
   endtask : frm
   task give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= '0;
      chk(expo_live, cegs_pkg::EXPO_RST);
      pulse(0, 24'h000400);
      frm(24'h000400);
      pulse(1, 24'h000020);
      chk(gain_live, 10'h020);
      // dark frames step up to the limit
      pulse(2, cegs_pkg::AUTO_CONT);
      pulse(4, 24'h000010);
      chk(expo_live, 24'h000481);
      pulse(4, 24'h000010);
      chk(expo_live, 24'h000500);
      @(posedge core_clk) trig_en <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(expo_auto_mode, cegs_pkg::AUTO_OFF);
      pulse(3, cegs_pkg::AUTO_ONCE);
      pulse(4, 24'h000010);
      chk(gain_live, 10'h025);
      pulse(4, 24'h000084);
      chk(gain_auto_mode, cegs_pkg::AUTO_OFF);
      // save two sets, then run them
      @(posedge core_clk) seq_cfg_mode <= 1'b1;
      pulse(6, 24'h0);
      pulse(0, 24'h000123);
      @(posedge core_clk) seq_sel <= 3'h1;
      pulse(6, 24'h0);
      @(posedge core_clk) {seq_mode, multi_expo_en} <= 2'h3;
      repeat (3) @(posedge core_clk);
      chk(multi_expo_active, 1'b0);
      chk(seq_active, 1'b1);
      pulse(9, 24'h1);
      chk(range_mode, cegs_pkg::RANGE_STD);
      chk(trig_width, 16'h0);
      frm(24'h000500);
      frm(24'h000123);
      frm(24'h000500);
      pulse(8, 24'h0);
      frm(24'h000500);
      chk(frame_set, 3'h0);
      pulse(0, 24'h000777);
      pulse(6, 24'h0);
      @(posedge core_clk) {seq_mode, multi_expo_en} <= 2'h0;
      pulse(7, 24'h0);
      chk(expo_live, 24'h000123);
      pulse(9, 24'h1);
      chk(range_mode, cegs_pkg::RANGE_ULTRA);
      chk(trig_width, 16'h1);
      // two groups, then half rate
      pulse(10, 24'h0000aa);
      @(posedge core_clk) multi_expo_index <= 2'h1;
      pulse(10, 24'h0000bb);
      @(posedge core_clk) multi_expo_en <= 1'b1;
      repeat (2) @(posedge core_clk);
      frm(24'h0000aa);
      frm(24'h0000bb);
      chk(frame_gain, 10'h0bb);
      @(posedge core_clk) shutter_mode <= cegs_pkg::SHUT_GRST;
      gos = 0;
      repeat (4) begin
         pulse(5, 24'h0);
         gos += (frame_go === 1'b1);
      end
      chk(gos, 2);
      // plain frame, then shift 1 and decimate 2
      @(posedge core_clk) multi_expo_en <= 1'b0;
      pulse(11, 24'h0);
      repeat (20) @(posedge core_clk);
      got.delete();
      {dshift_en_in, dshift_in, decim_h, decim_v} <= {1'b1, 3'h1, 4'h2, 4'h2};
      pulse(11, 24'h0);
      repeat (20) @(posedge core_clk);
      chk(got.size(), 4);
      for (int i = 0; i < 4; i++) chk(got[i], 12'h140 + 12'(i[0] * 4 + i[1] * 16));
      give_verdict();
   end
endmodule : test_cegs_top
